/* test/test_mixer_synth_tuning_registers.sv */
// self-checking bench for the tuning register slice
`timescale 1ns/100ps
`default_nettype none
`include "mst_defines.svh"
module test_mixer_synth_tuning_registers;
    import mst_pkg::*;
    logic core_clk, reset_n, reg_wr_en, reg_rd_en, cal_update, reg_rd_valid;
    logic [6:0] reg_addr;
    mst_word_t reg_wdata, reg_rdata;
    logic ph_sign, slew_sign;
    logic [5:0] ph_code;
    logic [3:0] lo_div;
    logic [1:0] pll_lock_state, lna_cfg, term;
    logic [2:0] core;
    logic [7:0] cap;
    logic [8:0] amp;
    int err_total, checks;
    mst_word_t m [128];
    logic [6:0] regs [8] = '{`MST_OFF_PHASE, `MST_OFF_LODIV, `MST_OFF_PLLST, `MST_OFF_CAPRB,
        `MST_OFF_AMPRB, `MST_OFF_LNA, `MST_OFF_TERM, 7'h10};
    mst_regs mst_regs_inst (.core_clk(core_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .pll_lock_state(pll_lock_state),
        .osc_core_selected(core), .osc_cap_code(cap), .osc_amp_code(amp),
        .cal_update(cal_update), .image_phase_interp_sign(ph_sign),
        .image_phase_interp_code(ph_code), .image_phase_slew_sign(slew_sign),
        .lo_divider_config(lo_div), .lna_bias_current_cfg(lna_cfg), .ext_lo_termination(term));
    // ==========================================
    // expectations
    function automatic mst_word_t wmask(input logic [6:0] a);
        case (a)
            `MST_OFF_PHASE: return 16'hff00;
            `MST_OFF_LODIV: return 16'h3c00;
            `MST_OFF_LNA: return 16'h0060;
            `MST_OFF_TERM: return 16'h0003;
            default: return 16'h0000;
        endcase
    endfunction : wmask
    // control outputs packed into their register positions
    function automatic mst_word_t outs(input logic [6:0] a);
        case (a)
            `MST_OFF_PHASE: return {ph_sign, ph_code, slew_sign, 8'h00};
            `MST_OFF_LODIV: return {2'h0, lo_div, 10'h000};
            `MST_OFF_LNA: return {9'h000, lna_cfg, 5'h00};
            `MST_OFF_TERM: return {14'h0000, term};
            default: return m[a];
        endcase
    endfunction : outs
    // ==========================================
    // drivers and compares
    task automatic chk_word(input string what, input mst_word_t exp, input mst_word_t got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_flag(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag
    // strobes stay up between calls so transfers run back to back
    task automatic wr(input logic [6:0] a, input mst_word_t d);
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk) #1;
        if (wmask(a) != 16'h0000) m[a] = d & wmask(a);
        // every control word is checked, so a stray write to any other word shows up
        foreach (regs[k]) begin
            if (wmask(regs[k]) != 16'h0000) begin
                chk_word("control outputs", m[regs[k]], outs(regs[k]));
            end
        end
    endtask : wr
    task automatic rd(input logic [6:0] a);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge core_clk) #1;
        chk_flag("read valid", 1'b1, reg_rd_valid);
        chk_word("read data", m[a], reg_rdata);
    endtask : rd
    task automatic idle;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        @(posedge core_clk) #1;
        chk_flag("read valid pulse", 1'b0, reg_rd_valid);
    endtask : idle
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        stop_test();
    end
    initial begin : main
        int i;
        {reset_n, reg_wr_en, reg_rd_en, cal_update, reg_addr, reg_wdata} = '0;
        {pll_lock_state, core, cap, amp} = '0;
        foreach (m[k]) m[k] = 16'h0000;
        m[`MST_OFF_TERM] = 16'h0003;
        void'($urandom(6251));
        repeat (3) @(posedge core_clk);
        #1 reset_n = 1'b1;
        foreach (regs[k]) rd(regs[k]);
        chk_word("reset outputs", 16'h0003, outs(`MST_OFF_TERM));
        idle();
        $display("reset values done");
        // status readback: lock walks all codes, codes change after the load strobe
        for (i = 0; i < 8; i++) begin
            pll_lock_state = i[1:0];
            core = 3'($urandom);
            cap = 8'($urandom);
            amp = 9'($urandom);
            cal_update = 1'b1;
            m[`MST_OFF_PLLST] = {5'h00, i[1:0], 1'b0, core, 5'h00};
            m[`MST_OFF_CAPRB] = {8'h00, cap};
            m[`MST_OFF_AMPRB] = {7'h00, amp};
            @(posedge core_clk) #1;
            cal_update = 1'b0;
            core = ~core;
            cap = 8'($urandom);
            amp = 9'($urandom);
            // the word read right after the load strobe alternates so both capture checks fire
            if (i[0]) begin
                rd(`MST_OFF_CAPRB);
                rd(`MST_OFF_AMPRB);
            end else begin
                rd(`MST_OFF_AMPRB);
                rd(`MST_OFF_CAPRB);
            end
            rd(`MST_OFF_PLLST);
            idle();
        end
        $display("status readback done");
        foreach (regs[k]) wr(regs[k], 16'hffff);
        foreach (regs[k]) rd(regs[k]);
        repeat (60) begin
            i = $urandom_range(0, 7);
            wr(regs[i], 16'($urandom));
            if ($urandom_range(0, 1) == 1) rd(regs[$urandom_range(0, 7)]);
        end
        idle();
        $display("random access done");
        stop_test();
    end
endmodule : test_mixer_synth_tuning_registers
`default_nettype wire

/* verilog/mst_defines.svh */
// register offsets, field positions and reset values of the tuning register slice
`ifndef MST_DEFINES_SVH
`define MST_DEFINES_SVH
// ==========================================
// offsets
`define MST_ADDR_W 7
`define MST_OFF_PHASE 7'h5F
`define MST_OFF_LODIV 7'h67
`define MST_OFF_PLLST 7'h6E
`define MST_OFF_CAPRB 7'h6F
`define MST_OFF_AMPRB 7'h70
`define MST_OFF_LNA 7'h79
`define MST_OFF_TERM 7'h7B
// ==========================================
// field positions
`define MST_INTERP_SIGN_BIT 15
`define MST_INTERP_CODE_HI 14
`define MST_INTERP_CODE_LO 9
`define MST_SLEW_SIGN_BIT 8
`define MST_LODIV_HI 13
`define MST_LODIV_LO 10
`define MST_LOCK_HI 10
`define MST_LOCK_LO 9
`define MST_CORE_HI 7
`define MST_CORE_LO 5
`define MST_LNA_HI 6
`define MST_LNA_LO 5
`define MST_TERM_HI 1
`define MST_TERM_LO 0
// ==========================================
// reset values
`define MST_TERM_RST 2'h3
`define MST_LNA_RST 2'h0
`define MST_CORE_RST 3'h0
`endif

/* verilog/mst_pkg.sv */
// types shared by the tuning register slice
package mst_pkg;
    typedef enum logic [1:0] {
        MST_LOCK_UNLOCK_LOW,
        MST_LOCK_INVALID,
        MST_LOCK_LOCKED,
        MST_LOCK_UNLOCK_HIGH
    } mst_lock_t;
    typedef logic [15:0] mst_word_t;
endpackage : mst_pkg

/* verilog/mst_regs.sv */
// tuning register slice: control fields and calibration/lock readback
`timescale 1ns/100ps
`default_nettype none
`include "mst_defines.svh"
module mst_regs
    import mst_pkg::*;
#(
    parameter int CAP_W = 8,
    parameter int AMP_W = 9
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`MST_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic [1:0] pll_lock_state,
    input wire logic [2:0] osc_core_selected,
    input wire logic [CAP_W-1:0] osc_cap_code,
    input wire logic [AMP_W-1:0] osc_amp_code,
    input wire logic cal_update,
    output logic image_phase_interp_sign,
    output logic [5:0] image_phase_interp_code,
    output logic image_phase_slew_sign,
    output logic [3:0] lo_divider_config,
    output logic [1:0] lna_bias_current_cfg,
    output logic [1:0] ext_lo_termination
);
    // ==========================================
    // decode
    wire logic hit_phase = (reg_addr == `MST_OFF_PHASE);
    wire logic hit_lodiv = (reg_addr == `MST_OFF_LODIV);
    wire logic hit_pllst = (reg_addr == `MST_OFF_PLLST);
    wire logic hit_caprb = (reg_addr == `MST_OFF_CAPRB);
    wire logic hit_amprb = (reg_addr == `MST_OFF_AMPRB);
    wire logic hit_lna = (reg_addr == `MST_OFF_LNA);
    wire logic hit_term = (reg_addr == `MST_OFF_TERM);
    // only writable words get a strobe, so status and unmapped writes fall away
    wire logic wr_phase = reg_wr_en && hit_phase;
    wire logic wr_lodiv = reg_wr_en && hit_lodiv;
    wire logic wr_lna = reg_wr_en && hit_lna;
    wire logic wr_term = reg_wr_en && hit_term;

    // ==========================================
    // status capture: core, cap and amp codes are held from cal_update so software sees a stable word; lock is resampled every clock
    logic [1:0] lock_r;
    logic [2:0] core_r;
    logic [CAP_W-1:0] cap_r;
    logic [AMP_W-1:0] amp_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_r <= 2'h0;
            core_r <= `MST_CORE_RST;
            cap_r <= '0;
            amp_r <= '0;
        end else begin
            lock_r <= pll_lock_state;
            if (cal_update) begin
                core_r <= osc_core_selected;
                cap_r <= osc_cap_code;
                amp_r <= osc_amp_code;
            end
        end
    end

    // ==========================================
    // control fields; reset values not defined for some, zero chosen
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            image_phase_interp_sign <= 1'b0;
            image_phase_interp_code <= 6'h0;
            image_phase_slew_sign <= 1'b0;
            lo_divider_config <= 4'h0;
            lna_bias_current_cfg <= `MST_LNA_RST;
            ext_lo_termination <= `MST_TERM_RST;
        end else begin
            if (wr_phase) begin
                image_phase_interp_sign <= reg_wdata[`MST_INTERP_SIGN_BIT];
                image_phase_interp_code <=
                    reg_wdata[`MST_INTERP_CODE_HI:`MST_INTERP_CODE_LO];
                image_phase_slew_sign <= reg_wdata[`MST_SLEW_SIGN_BIT];
            end
            if (wr_lodiv) begin
                lo_divider_config <= reg_wdata[`MST_LODIV_HI:`MST_LODIV_LO];
            end
            if (wr_lna) begin
                lna_bias_current_cfg <= reg_wdata[`MST_LNA_HI:`MST_LNA_LO];
            end
            if (wr_term) begin
                ext_lo_termination <= reg_wdata[`MST_TERM_HI:`MST_TERM_LO];
            end
        end
    end

    // ==========================================
    // read mux: only defined fields are placed, everything else stays zero
    mst_word_t rd_phase;
    mst_word_t rd_lodiv;
    mst_word_t rd_pllst;
    mst_word_t rd_caprb;
    mst_word_t rd_amprb;
    mst_word_t rd_lna;
    mst_word_t rd_term;
    mst_word_t rd_mux;
    always_comb begin
        rd_phase = 16'h0000;
        rd_phase[`MST_INTERP_SIGN_BIT] = image_phase_interp_sign;
        rd_phase[`MST_INTERP_CODE_HI:`MST_INTERP_CODE_LO] = image_phase_interp_code;
        rd_phase[`MST_SLEW_SIGN_BIT] = image_phase_slew_sign;
        rd_lodiv = 16'h0000;
        rd_lodiv[`MST_LODIV_HI:`MST_LODIV_LO] = lo_divider_config;
        rd_pllst = 16'h0000;
        rd_pllst[`MST_LOCK_HI:`MST_LOCK_LO] = lock_r;
        rd_pllst[`MST_CORE_HI:`MST_CORE_LO] = core_r;
        rd_caprb = 16'h0000;
        rd_caprb[CAP_W-1:0] = cap_r;
        rd_amprb = 16'h0000;
        rd_amprb[AMP_W-1:0] = amp_r;
        rd_lna = 16'h0000;
        rd_lna[`MST_LNA_HI:`MST_LNA_LO] = lna_bias_current_cfg;
        rd_term = 16'h0000;
        rd_term[`MST_TERM_HI:`MST_TERM_LO] = ext_lo_termination;
        if (hit_phase) rd_mux = rd_phase;
        else if (hit_lodiv) rd_mux = rd_lodiv;
        else if (hit_pllst) rd_mux = rd_pllst;
        else if (hit_caprb) rd_mux = rd_caprb;
        else if (hit_amprb) rd_mux = rd_amprb;
        else if (hit_lna) rd_mux = rd_lna;
        else if (hit_term) rd_mux = rd_term;
        else rd_mux = 16'h0000;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) reg_rdata <= rd_mux;
        end
    end

    // ==========================================
    // checks
    phase_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_phase |=> image_phase_interp_code == $past(reg_wdata[14:9])
            && image_phase_interp_sign == $past(reg_wdata[15]))
        else $error("phase field write lost");
    slew_sign_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_phase |=> image_phase_slew_sign == $past(reg_wdata[8]))
        else $error("slew sign write lost");
    lodiv_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !wr_lodiv |=> $stable(lo_divider_config))
        else $error("lo divider changed without write");
    lodiv_data_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_lodiv |=> lo_divider_config == $past(reg_wdata[13:10]))
        else $error("lo divider write lost");
    lna_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_lna |=> lna_bias_current_cfg == $past(reg_wdata[6:5]))
        else $error("lna bias write lost");
    lock_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_pllst |=> reg_rd_valid && reg_rdata[10:9] == $past(lock_r)
            && reg_rdata[15:11] == 5'h0 && reg_rdata[4:0] == 5'h0)
        else $error("lock status readback wrong");
    core_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_pllst |=> reg_rdata[7:5] == $past(core_r))
        else $error("core readback wrong");
    // the capture checks need a read right after the load strobe to mean anything
    cap_capture_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cal_update ##1 (reg_rd_en && hit_caprb) |=>
            reg_rdata[CAP_W-1:0] == $past(osc_cap_code, 2))
        else $error("cap code readback wrong");
    cap_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_caprb |=> reg_rdata[15:CAP_W] == '0)
        else $error("cap word upper bits not zero");
    amp_capture_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cal_update ##1 (reg_rd_en && hit_amprb) |=>
            reg_rdata[AMP_W-1:0] == $past(osc_amp_code, 2))
        else $error("amp code readback wrong");
    amp_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_amprb |=> reg_rdata[15:AMP_W] == '0)
        else $error("amp word upper bits not zero");
    term_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_term |=> ext_lo_termination == $past(reg_wdata[1:0]))
        else $error("termination write lost");
    term_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_term |=> reg_rdata == {14'h0000, $past(ext_lo_termination)})
        else $error("termination readback wrong");
    lna_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_lna |=> reg_rdata[15:7] == 9'h0 && reg_rdata[4:0] == 5'h0
            && reg_rdata[6:5] == $past(lna_bias_current_cfg))
        else $error("lna register readback wrong");
    phase_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_phase |=> reg_rdata[7:0] == 8'h00 && reg_rdata[15:8] ==
            $past({image_phase_interp_sign, image_phase_interp_code, image_phase_slew_sign}))
        else $error("phase register readback wrong");
    lodiv_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && hit_lodiv |=> reg_rdata == {2'h0, $past(lo_divider_config), 10'h000})
        else $error("lo divider readback wrong");
    ro_ignore_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_wr_en && (hit_caprb || hit_amprb) && !cal_update |=>
            $stable(cap_r) && $stable(amp_r))
        else $error("write reached read-only field");
    // a stray write must not disturb any analog setting
    ro_ctl_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_wr_en && !(hit_phase || hit_lodiv || hit_lna || hit_term) |=>
            $stable({image_phase_interp_sign, image_phase_interp_code, image_phase_slew_sign,
                lo_divider_config, lna_bias_current_cfg, ext_lo_termination}))
        else $error("write to read-only or unmapped word changed a control");
    unmapped_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en && !(hit_phase || hit_lodiv || hit_pllst || hit_caprb || hit_amprb
            || hit_lna || hit_term) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    rd_valid_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd_en |=> reg_rd_valid)
        else $error("read valid missing");
    rd_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !reg_rd_en |=> !reg_rd_valid)
        else $error("read valid without read");
endmodule : mst_regs
`default_nettype wire
